// file: logic/counter_routing_regs.vh
// Selector, route and mode codes for the counter signal routing block
`ifndef COUNTER_ROUTING_REGS_VH
`define COUNTER_ROUTING_REGS_VH

// Selector code: 6 bits
// 6'h00-6'h0F programmable I/O line, 6'h10-6'h17 trigger bus line,
// 6'h20-6'h2F block-specific choice from the lists below
`define SEL_W        6
`define SEL_SPEC_BIT 5
`define SEL_TRIG_BIT 4
`define SEL_RST      6'h00

// Counting source choices
`define SRC_TB80      6'h20
`define SRC_TB20      6'h21
`define SRC_TB100K    6'h22
`define SRC_REFCLK    6'h23
`define SRC_STAR      6'h24
`define SRC_CMP       6'h25
`define SRC_OTHER_TC  6'h26
`define SRC_OTHER_GT  6'h27

// Gate choices
`define GATE_ACQ_REF   6'h20
`define GATE_ACQ_START 6'h21
`define GATE_ACQ_SAMP  6'h22
`define GATE_ACQ_CONV  6'h23
`define GATE_AO_SAMP   6'h24
`define GATE_DI_SAMP   6'h25
`define GATE_DO_SAMP   6'h26
`define GATE_STAR      6'h27
`define GATE_CHG       6'h28
`define GATE_CMP       6'h29
`define GATE_OTHER_OUT 6'h2A
`define GATE_OTHER_SRC 6'h2B

// Auxiliary choices
`define AUX_ACQ_REF   6'h20
`define AUX_ACQ_START 6'h21
`define AUX_STAR      6'h22
`define AUX_CMP       6'h23
`define AUX_OTHER_OUT 6'h24
`define AUX_OTHER_GT  6'h25
`define AUX_OTHER_SRC 6'h26
`define AUX_OWN_GT    6'h27

// Encoder A/B/Z choices
`define ENC_STAR 6'h20
`define ENC_CMP  6'h21

// Hardware arm choices
`define ARM_ACQ_REF   6'h20
`define ARM_ACQ_START 6'h21
`define ARM_STAR      6'h22
`define ARM_CMP       6'h23
`define ARM_OTHER_OUT 6'h24

// Output line route codes
`define ROUTE_W      4
`define ROUTE_NONE   4'h0
`define ROUTE_SRC0   4'h1
`define ROUTE_GATE0  4'h2
`define ROUTE_OUT0   4'h3
`define ROUTE_SRC1   4'h4
`define ROUTE_GATE1  4'h5
`define ROUTE_OUT1   4'h6
`define ROUTE_FREQ   4'h7
`define ROUTE_Z0     4'h8
`define ROUTE_Z1     4'h9
`define PIO_ROUTE_OK 16'h00FE
`define TRB_ROUTE_OK 16'h037E

// Start modes
`define START_IMM  2'h0
`define START_GATE 2'h1
`define START_AUX  2'h2

// Gate actions
`define GATE_NONE  2'h0
`define GATE_STOP  2'h2
`define GATE_LATCH 2'h3

// Direction modes
`define DIR_DOWN 2'h0
`define DIR_UP   2'h1
`define DIR_ENCB 2'h2

// Frequency generator
`define FREQ_DIV_W   5
`define FREQ_DIV_MAX 5'h10

`endif

// file: logic/counter_signal_routing.v
// Counter signal routing: input selectors, two counters, freq generator
`timescale 1ns/10ps
`include "counter_routing_regs.vh"

module counter_signal_routing #(
   parameter CW = 32
) (
   input  wire            clk,
   input  wire            resetn,
   input  wire [15:0]     progIoIn,
   input  wire [7:0]      trigBusIn,
   input  wire            timebase80,
   input  wire            timebase20,
   input  wire            timebase100k,
   input  wire            backplaneRefClock,
   input  wire            backplaneStarTrigger,
   input  wire            analogCmpEvent,
   input  wire            acqReferenceTrigger,
   input  wire            acqStartTrigger,
   input  wire            acqSampleClock,
   input  wire            acqConvertClock,
   input  wire            analogOutSampleClock,
   input  wire            digitalInSampleClock,
   input  wire            digitalOutSampleClock,
   input  wire            changeDetectEvent,
   input  wire [11:0]     srcSel,
   input  wire [11:0]     gateSel,
   input  wire [11:0]     auxSel,
   input  wire [11:0]     encASel,
   input  wire [11:0]     encBSel,
   input  wire [11:0]     encZSel,
   input  wire [11:0]     armSel,
   input  wire [1:0]      srcFalling,
   input  wire [1:0]      swArm,
   input  wire [1:0]      swDisarm,
   input  wire [1:0]      hwArmEn,
   input  wire [3:0]      startMode,
   input  wire [3:0]      gateMode,
   input  wire [3:0]      dirMode,
   input  wire [1:0]      outToggle,
   input  wire [1:0]      outInvert,
   input  wire [1:0]      loadStrobe,
   input  wire [2*CW-1:0] loadValue,
   input  wire [63:0]     progIoRoute,
   input  wire [31:0]     trigBusRoute,
   input  wire            freqEn,
   input  wire            freqSlowTb,
   input  wire [3:0]      freqDiv,
   input  wire            freqToDoClk,
   input  wire            freqToDiClk,
   output reg  [15:0]     progIoOut,
   output reg  [15:0]     progIoOe,
   output reg  [7:0]      trigBusOut,
   output reg  [7:0]      trigBusOe,
   output wire [2*CW-1:0] countValue,
   output wire [2*CW-1:0] latchedValue,
   output wire [1:0]      armedStatus,
   output reg  [1:0]      terminalCount,
   output reg  [1:0]      internalOut,
   output reg  [5:0]      encoderLevels,
   output reg             freqGenOutput,
   output reg             doSampleClkOut,
   output reg             diSampleClkOut
);

   localparam EXT_W = 38;

   // Shared picker for every input selector
   function pick;
      input [`SEL_W-1:0] code;
      input [15:0]       pio;
      input [7:0]        trb;
      input [15:0]       spec;
      begin
         if (code[`SEL_SPEC_BIT]) begin
            pick = spec[code[3:0]];
         end else if (code[`SEL_TRIG_BIT]) begin
            pick = trb[code[2:0]];
         end else begin
            pick = pio[code[3:0]];
         end
      end
   endfunction

   function edgeOf;
      input lvl;
      input prev;
      input falling;
      begin
         edgeOf = falling ? (prev & ~lvl) : (~prev & lvl);
      end
   endfunction

   reg  [EXT_W-1:0] syncA_reg;
   reg  [EXT_W-1:0] syncB_reg;
   wire [EXT_W-1:0] extIn;
   wire [15:0]      pioS;
   wire [7:0]       trbS;
   wire             tb80S;
   wire             tb20S;
   wire             tb100kS;
   wire             refClkS;
   wire             starS;
   wire             cmpS;
   wire             acqRefS;
   wire             acqStartS;
   wire             acqSampS;
   wire             acqConvS;
   wire             aoSampS;
   wire             diSampS;
   wire             doSampS;
   wire             chgS;

   assign extIn = {changeDetectEvent, digitalOutSampleClock,
                   digitalInSampleClock, analogOutSampleClock,
                   acqConvertClock, acqSampleClock, acqStartTrigger,
                   acqReferenceTrigger, analogCmpEvent,
                   backplaneStarTrigger, backplaneRefClock, timebase100k,
                   timebase20, timebase80, trigBusIn, progIoIn};

   // Two-stage synchroniser; stage A feeds stage B only
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         syncA_reg <= {EXT_W{1'b0}};
         syncB_reg <= {EXT_W{1'b0}};
      end else begin
         syncA_reg <= extIn;
         syncB_reg <= syncA_reg;
      end
   end

   assign {chgS, doSampS, diSampS, aoSampS, acqConvS, acqSampS,
           acqStartS, acqRefS, cmpS, starS, refClkS, tb100kS, tb20S,
           tb80S, trbS, pioS} = syncB_reg;

   reg  [1:0]    srcLvl_reg;
   reg  [1:0]    srcPrev_reg;
   reg  [1:0]    gateLvl_reg;
   reg  [1:0]    gatePrev_reg;
   reg  [1:0]    auxLvl_reg;
   reg  [1:0]    auxPrev_reg;
   reg  [1:0]    armLvl_reg;
   reg  [1:0]    armPrev_reg;
   reg  [1:0]    encA_reg;
   reg  [1:0]    encB_reg;
   reg  [1:0]    encZ_reg;
   wire [1:0]    tcW;
   wire [1:0]    outW;

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : ctr
         wire [15:0] srcSpec;
         wire [15:0] gateSpec;
         wire [15:0] auxSpec;
         wire [15:0] encSpec;
         wire [15:0] armSpec;
         wire [5:0]  sSel;

         assign sSel = srcSel[6*i +: 6];
         assign srcSpec  = {8'h00, gateLvl_reg[1-i], tcW[1-i], cmpS,
                            starS, refClkS, tb100kS, tb20S, tb80S};
         assign gateSpec = {4'h0, srcLvl_reg[1-i], outW[1-i], cmpS,
                            chgS, starS, doSampS, diSampS, aoSampS,
                            acqConvS, acqSampS, acqStartS, acqRefS};
         assign auxSpec  = {8'h00, gateLvl_reg[i], srcLvl_reg[1-i],
                            gateLvl_reg[1-i], outW[1-i], cmpS, starS,
                            acqStartS, acqRefS};
         assign encSpec  = {14'h0000, cmpS, starS};
         assign armSpec  = {11'h000, outW[1-i], cmpS, starS, acqStartS,
                            acqRefS};

         // Registered picks break loops through cross-counter choices
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               srcLvl_reg[i]   <= 1'b0;
               srcPrev_reg[i]  <= 1'b0;
               gateLvl_reg[i]  <= 1'b0;
               gatePrev_reg[i] <= 1'b0;
               auxLvl_reg[i]   <= 1'b0;
               auxPrev_reg[i]  <= 1'b0;
               armLvl_reg[i]   <= 1'b0;
               armPrev_reg[i]  <= 1'b0;
               encA_reg[i]     <= 1'b0;
               encB_reg[i]     <= 1'b0;
               encZ_reg[i]     <= 1'b0;
            end else begin
               srcLvl_reg[i]   <= pick(sSel, pioS, trbS, srcSpec);
               gateLvl_reg[i]  <= pick(gateSel[6*i +: 6], pioS, trbS,
                                       gateSpec);
               auxLvl_reg[i]   <= pick(auxSel[6*i +: 6], pioS, trbS,
                                       auxSpec);
               armLvl_reg[i]   <= pick(armSel[6*i +: 6], pioS, trbS,
                                       armSpec);
               encA_reg[i]     <= pick(encASel[6*i +: 6], pioS, trbS,
                                       encSpec);
               encB_reg[i]     <= pick(encBSel[6*i +: 6], pioS, trbS,
                                       encSpec);
               encZ_reg[i]     <= pick(encZSel[6*i +: 6], pioS, trbS,
                                       encSpec);
               srcPrev_reg[i]  <= srcLvl_reg[i];
               gatePrev_reg[i] <= gateLvl_reg[i];
               auxPrev_reg[i]  <= auxLvl_reg[i];
               armPrev_reg[i]  <= armLvl_reg[i];
            end
         end

         // Source is timebase or measured input; the core counts either
         gp_counter #(
            .CW (CW)
         ) core (
            .clk         (clk),
            .resetn      (resetn),
            .srcEdge     (edgeOf(srcLvl_reg[i], srcPrev_reg[i],
                                 srcFalling[i])),
            .gateEdge    (edgeOf(gateLvl_reg[i], gatePrev_reg[i], 1'b0)),
            .auxEdge     (edgeOf(auxLvl_reg[i], auxPrev_reg[i], 1'b0)),
            .armEdge     (edgeOf(armLvl_reg[i], armPrev_reg[i], 1'b0)),
            .encB        (encB_reg[i]),
            .swArm       (swArm[i]),
            .swDisarm    (swDisarm[i]),
            .hwArmEn     (hwArmEn[i]),
            .startMode   (startMode[2*i +: 2]),
            .gateMode    (gateMode[2*i +: 2]),
            .dirMode     (dirMode[2*i +: 2]),
            .outToggle   (outToggle[i]),
            .outInvert   (outInvert[i]),
            .load        (loadStrobe[i]),
            .loadValue   (loadValue[CW*i +: CW]),
            .count_reg   (countValue[CW*i +: CW]),
            .latched_reg (latchedValue[CW*i +: CW]),
            .armed_reg   (armedStatus[i]),
            .tc          (tcW[i]),
            .intOut      (outW[i])
         );
      end
   endgenerate

   // Frequency generator
   reg                   tbHalf_reg;
   reg                   tb20Prev_reg;
   reg                   tbPrev_reg;
   reg  [`FREQ_DIV_W-1:0] phase_reg;
   wire                  tbLvl;
   wire                  tbEdge;
   wire [`FREQ_DIV_W-1:0] divD;
   wire [`FREQ_DIV_W-1:0] lowCnt;
   wire [`FREQ_DIV_W-1:0] phaseInc;
   wire                  freqNext;

   assign tbLvl    = freqSlowTb ? tb100kS : tbHalf_reg;
   assign tbEdge   = edgeOf(tbLvl, tbPrev_reg, 1'b0);
   // Divider field 0 stands for 16
   assign divD     = (freqDiv == 4'h0) ? `FREQ_DIV_MAX : {1'b0, freqDiv};
   assign lowCnt   = (divD + 5'h01) >> 1;
   assign phaseInc = (phase_reg == divD - 5'h01) ? 5'h00
                                                  : phase_reg + 5'h01;
   assign freqNext = (divD == 5'h01) ? tbLvl : (phase_reg >= lowCnt);

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tbHalf_reg     <= 1'b0;
         tb20Prev_reg   <= 1'b0;
         tbPrev_reg     <= 1'b0;
         phase_reg      <= 5'h00;
         freqGenOutput  <= 1'b0;
         doSampleClkOut <= 1'b0;
         diSampleClkOut <= 1'b0;
      end else begin
         tb20Prev_reg <= tb20S;
         if (tb20S & ~tb20Prev_reg) begin
            tbHalf_reg <= ~tbHalf_reg;
         end
         tbPrev_reg <= tbLvl;
         if (!freqEn) begin
            phase_reg <= 5'h00;
         end else if (tbEdge) begin
            phase_reg <= phaseInc;
         end
         freqGenOutput  <= freqEn & freqNext;
         doSampleClkOut <= freqToDoClk & freqEn & freqNext;
         diSampleClkOut <= freqToDiClk & freqEn & freqNext;
      end
   end

   // Output line routing
   wire [15:0] cand;
   wire [15:0] pioOk = `PIO_ROUTE_OK, trbOk = `TRB_ROUTE_OK;
   integer     k;
   assign cand = {6'h00, encZ_reg[1], encZ_reg[0], freqGenOutput,
                  outW[1], gateLvl_reg[1], srcLvl_reg[1], outW[0],
                  gateLvl_reg[0], srcLvl_reg[0], 1'b0};

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         progIoOut     <= 16'h0000;
         progIoOe      <= 16'h0000;
         trigBusOut    <= 8'h00;
         trigBusOe     <= 8'h00;
         terminalCount <= 2'h0;
         internalOut   <= 2'h0;
         encoderLevels <= 6'h00;
      end else begin
         for (k = 0; k < 16; k = k + 1) begin
            progIoOut[k] <= cand[progIoRoute[4*k +: 4]];
            progIoOe[k]  <= pioOk[progIoRoute[4*k +: 4]];
         end
         for (k = 0; k < 8; k = k + 1) begin
            trigBusOut[k] <= cand[trigBusRoute[4*k +: 4]];
            trigBusOe[k]  <= trbOk[trigBusRoute[4*k +: 4]];
         end
         terminalCount <= tcW;
         internalOut   <= outW;
         encoderLevels <= {encZ_reg, encB_reg, encA_reg};
      end
   end

endmodule // counter_signal_routing

// file: logic/gp_counter.v
// One general-purpose counter: arming, start, gate actions, terminal count
`timescale 1ns/10ps
`include "counter_routing_regs.vh"

module gp_counter #(
   parameter CW = 32
) (
   input  wire          clk,
   input  wire          resetn,
   input  wire          srcEdge,
   input  wire          gateEdge,
   input  wire          auxEdge,
   input  wire          armEdge,
   input  wire          encB,
   input  wire          swArm,
   input  wire          swDisarm,
   input  wire          hwArmEn,
   input  wire [1:0]    startMode,
   input  wire [1:0]    gateMode,
   input  wire [1:0]    dirMode,
   input  wire          outToggle,
   input  wire          outInvert,
   input  wire          load,
   input  wire [CW-1:0] loadValue,
   output reg  [CW-1:0] count_reg,
   output reg  [CW-1:0] latched_reg,
   output reg           armed_reg,
   output wire          tc,
   output wire          intOut
);

   reg  running_reg;
   reg  tcPrev_reg;
   reg  outState_reg;
   wire countUp;
   wire tcRise;

   assign tc      = (count_reg == {CW{1'b0}});
   assign tcRise  = tc & ~tcPrev_reg & armed_reg;
   // Encoder B doubles as the up/down control
   assign countUp = (dirMode == `DIR_ENCB) ? encB :
                    (dirMode == `DIR_UP);
   assign intOut  = outState_reg ^ outInvert;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         armed_reg    <= 1'b0;
         running_reg  <= 1'b0;
         count_reg    <= {CW{1'b0}};
         latched_reg  <= {CW{1'b0}};
         tcPrev_reg   <= 1'b0;
         outState_reg <= 1'b0;
      end else begin
         tcPrev_reg <= tc;
         if (swDisarm) begin
            armed_reg   <= 1'b0;
            running_reg <= 1'b0;
         end else begin
            if (swArm | (hwArmEn & armEdge)) begin
               armed_reg <= 1'b1;
            end
            // Nothing starts before the counter is armed
            if (armed_reg & ~running_reg) begin
               case (startMode)
                  `START_IMM: running_reg <= 1'b1;
                  `START_GATE: begin
                     if (gateEdge) running_reg <= 1'b1;
                  end
                  `START_AUX: begin
                     if (auxEdge) running_reg <= 1'b1;
                  end
                  default: running_reg <= 1'b0;
               endcase
            end else if (running_reg & gateEdge &
                         (gateMode == `GATE_STOP)) begin
               running_reg <= 1'b0;
            end
         end
         if (armed_reg & gateEdge & (gateMode == `GATE_LATCH)) begin
            latched_reg <= count_reg;
         end
         if (load) begin
            count_reg <= loadValue;
         end else if (running_reg & srcEdge) begin
            count_reg <= countUp ? count_reg + 1'b1 : count_reg - 1'b1;
         end
         if (outToggle) begin
            if (tcRise) outState_reg <= ~outState_reg;
         end else begin
            outState_reg <= tcRise;
         end
      end
   end

endmodule // gp_counter

// file: verification/counter_signal_routing_properties.sv
// Port-level checks of the counter signal routing block
`timescale 1ns/10ps
module counter_routing_checker #(
   parameter CW = 32
) (
   input wire logic            clk,
   input wire logic            resetn,
   input wire logic [63:0]     progIoRoute,
   input wire logic [15:0]     progIoOe,
   input wire logic [2*CW-1:0] countValue,
   input wire logic [1:0]      loadStrobe,
   input wire logic [1:0]      armedStatus,
   input wire logic [1:0]      swArm,
   input wire logic [1:0]      swDisarm,
   input wire logic [1:0]      terminalCount,
   input wire logic [1:0]      internalOut,
   input wire logic [1:0]      outToggle,
   input wire logic [1:0]      outInvert,
   input wire logic            freqEn,
   input wire logic            freqGenOutput
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_idle_line_hiz:
      assert property (progIoRoute[3:0] == 4'h0 |=> !progIoOe[0])
         else $error("unrouted line driven");
   a_tc_at_zero:
      assert property (1'b1 |=> terminalCount[0] ==
         ($past(countValue[CW-1:0]) == 0)) else $error("tc wrong");
   a_idle_no_count:
      assert property (!armedStatus[0] && !$past(armedStatus[0]) &&
         !loadStrobe[0] |=> $stable(countValue[CW-1:0]))
         else $error("count moved while unarmed");
   a_count_one_step:
      assert property (!loadStrobe[0] |=>
         countValue[CW-1:0] == $past(countValue[CW-1:0]) ||
         countValue[CW-1:0] == $past(countValue[CW-1:0]) + 1'b1 ||
         countValue[CW-1:0] == $past(countValue[CW-1:0]) - 1'b1)
         else $error("count jumped");
   a_sw_arm_taken:
      assert property (swArm[0] && !swDisarm[0] |=> armedStatus[0])
         else $error("arm not taken");
   a_arm_holds:
      assert property (armedStatus[0] && !swDisarm[0] |=> armedStatus[0])
         else $error("arm lost");
   a_pulse_one_cycle:
      assert property (internalOut[0] && !outToggle[0] && !outInvert[0]
         |=> !internalOut[0]) else $error("pulse too long");
   a_freq_off_low:
      assert property (!freqEn |=> !freqGenOutput)
         else $error("freq output while off");
endmodule // counter_routing_checker

bind counter_signal_routing counter_routing_checker #(.CW(CW)) chk (
   .clk(clk), .resetn(resetn), .progIoRoute(progIoRoute),
   .progIoOe(progIoOe), .countValue(countValue), .loadStrobe(loadStrobe),
   .armedStatus(armedStatus), .swArm(swArm), .swDisarm(swDisarm),
   .terminalCount(terminalCount), .internalOut(internalOut),
   .outToggle(outToggle), .outInvert(outInvert), .freqEn(freqEn),
   .freqGenOutput(freqGenOutput));

// file: verification/counter_signal_routing_tb.sv
// Self-checking bench for the counter signal routing block
`timescale 1ns/10ps
`include "counter_routing_regs.vh"
module counter_signal_routing_tb;
   wire  [15:0] progIoIn, progIoOut, progIoOe;
   wire  [7:0]  trigBusIn, trigBusOut, trigBusOe;
   wire         tb100k, freqGenOutput, doSampleClkOut, diSampleClkOut;
   wire  [63:0] countValue, latchedValue;
   wire  [1:0]  armedStatus, terminalCount, internalOut;
   wire  [5:0]  encoderLevels;
   logic        clk, resetn, acqStart, freqEn, freqToDoClk, seenOut;
   logic [11:0] srcSel, gateSel, encBSel, armSel, auxSel, encASel, encZSel;
   logic [1:0]  srcFalling, outInvert;
   logic [31:0] trigBusRoute;
   logic [6:0]  extLvl;
   logic        freqSlowTb, freqToDiClk;
   logic [1:0]  swArm, swDisarm, hwArmEn, loadStrobe, outToggle;
   logic [3:0]  startMode, gateMode, dirMode, freqDiv;
   logic [63:0] loadValue, progIoRoute;
   integer      n_fail, samples_checked, cycles;

   signal_source_model src (.clk(clk), .progIoIn(progIoIn),
      .trigBusIn(trigBusIn), .timebase100k(tb100k));

   counter_signal_routing #(.CW(32)) DUT (
      .clk(clk), .resetn(resetn), .progIoIn(progIoIn),
      .trigBusIn(trigBusIn), .timebase80(1'b0), .timebase20(extLvl[0]),
      .timebase100k(tb100k), .backplaneRefClock(1'b0),
      .backplaneStarTrigger(extLvl[1]), .analogCmpEvent(extLvl[2]),
      .acqReferenceTrigger(extLvl[3]), .acqStartTrigger(acqStart),
      .acqSampleClock(1'b0), .acqConvertClock(1'b0),
      .analogOutSampleClock(1'b0), .digitalInSampleClock(extLvl[4]),
      .digitalOutSampleClock(extLvl[5]), .changeDetectEvent(extLvl[6]),
      .srcSel(srcSel), .gateSel(gateSel), .auxSel(auxSel),
      .encASel(encASel), .encBSel(encBSel), .encZSel(encZSel),
      .armSel(armSel), .srcFalling(srcFalling), .swArm(swArm),
      .swDisarm(swDisarm), .hwArmEn(hwArmEn), .startMode(startMode),
      .gateMode(gateMode), .dirMode(dirMode), .outToggle(outToggle),
      .outInvert(outInvert), .loadStrobe(loadStrobe), .loadValue(loadValue),
      .progIoRoute(progIoRoute), .trigBusRoute(trigBusRoute), .freqEn(freqEn),
      .freqSlowTb(freqSlowTb), .freqDiv(freqDiv), .freqToDoClk(freqToDoClk),
      .freqToDiClk(freqToDiClk), .progIoOut(progIoOut), .progIoOe(progIoOe),
      .trigBusOut(trigBusOut), .trigBusOe(trigBusOe),
      .countValue(countValue), .latchedValue(latchedValue),
      .armedStatus(armedStatus), .terminalCount(terminalCount),
      .internalOut(internalOut), .encoderLevels(encoderLevels),
      .freqGenOutput(freqGenOutput), .doSampleClkOut(doSampleClkOut),
      .diSampleClkOut(diSampleClkOut));

   task check(input string what, input logic [63:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task waitFreq(input logic v);
      integer k;
      for (k = 0; k < 300 && freqGenOutput !== v; k++) tick(1);
   endtask

   task t_reset;
      tick(2);
      check("pio oe", progIoOe, 16'h0000);
      check("armed", armedStatus, 2'h0);
   endtask
   task t_count;
      srcSel[5:0] = 6'h03;
      dirMode[1:0] = `DIR_UP;
      src.pulse(3, 2);
      tick(6);
      check("idle count", countValue[31:0], 32'h0);
      swArm[0] = 1'b1;
      tick(1);
      swArm[0] = 1'b0;
      tick(3);
      src.pulse(3, 5);
      tick(6);
      check("count up", countValue[31:0], 32'h5);
      progIoRoute[23:20] = `ROUTE_SRC0;
      src.setLine(3, 1'b1);
      tick(6);
      check("src out", {progIoOe[5], progIoOut[5]}, 2'h3);
      src.setLine(3, 1'b0);
      tick(6);
      check("src out", {progIoOe[5], progIoOut[5]}, 2'h2);
   endtask
   task t_tc;
      loadValue[31:0] = 32'h2;
      dirMode[1:0] = `DIR_DOWN;
      loadStrobe[0] = 1'b1;
      tick(1);
      loadStrobe[0] = 1'b0;
      tick(2);
      check("tc off", terminalCount[0], 1'b0);
      seenOut = 1'b0;
      src.pulse(3, 2);
      tick(6);
      check("count down", countValue[31:0], 32'h0);
      check("tc on", terminalCount[0], 1'b1);
      check("out pulse", seenOut, 1'b1);
   endtask
   task t_latch;
      dirMode[1:0] = `DIR_UP;
      gateMode[1:0] = `GATE_LATCH;
      gateSel[5:0] = 6'h10;
      src.pulse(3, 3);
      src.pulse(16, 1);
      tick(6);
      check("latched", latchedValue[31:0], 32'h3);
      check("count kept", countValue[31:0], 32'h3);
   endtask
   task t_route;
      srcFalling[0] = 1'b1;
      src.pulse(3, 1);
      tick(6);
      check("fall count", countValue[31:0], 32'h4);
      srcFalling[0] = 1'b0;
      encZSel[5:0] = `ENC_STAR;
      trigBusRoute[3:0] = `ROUTE_Z0;
      extLvl[1] = 1'b1;
      tick(6);
      check("z out", {trigBusOe[0], trigBusOut[0]}, 2'h3);
      check("z level", encoderLevels[4], 1'b1);
      outInvert[0] = 1'b1;
      tick(2);
      check("inverted", internalOut[0], 1'b1);
      outInvert[0] = 1'b0;
   endtask
   task t_encoder;
      srcSel[11:6] = 6'h11;
      encBSel[11:6] = 6'h12;
      dirMode[3:2] = `DIR_ENCB;
      outToggle[1] = 1'b1;
      hwArmEn[1] = 1'b1;
      armSel[11:6] = `ARM_ACQ_START;
      tick(4);
      check("hw idle", armedStatus[1], 1'b0);
      acqStart = 1'b1;
      tick(4);
      acqStart = 1'b0;
      tick(4);
      check("hw armed", armedStatus[1], 1'b1);
      src.setLine(18, 1'b1);
      src.pulse(17, 2);
      tick(6);
      check("enc up", countValue[63:32], 32'h2);
      src.setLine(18, 1'b0);
      src.pulse(17, 2);
      tick(6);
      check("enc down", countValue[63:32], 32'h0);
      check("toggle", internalOut[1], 1'b1);
   endtask
   task t_freq;
      integer i, d, hi, lo;
      progIoRoute[31:28] = `ROUTE_FREQ;
      {freqToDoClk, freqToDiClk} = 2'h3;
      for (i = 0; i < 4; i++) begin
         d = (i == 0) ? 1 : (i == 1) ? 4 : (i == 2) ? 5 : 16;
         freqDiv = d[3:0];
         freqEn = 1'b1;
         waitFreq(1'b1);
         waitFreq(1'b0);
         waitFreq(1'b1);
         for (hi = 0; hi < 200 && freqGenOutput === 1'b1; hi++) tick(1);
         for (lo = 0; lo < 200 && freqGenOutput === 1'b0; lo++) tick(1);
         check("freq period", hi + lo, d * 8);
         check("freq high", hi, (d == 1) ? 4 : (d / 2) * 8);
         if (i < 3) freqEn = 1'b0;
         tick(2);
      end
      check("freq pins", {progIoOe[7], progIoOut[7], doSampleClkOut,
         diSampleClkOut}, 4'hF);
   endtask

   always @(posedge clk) begin
      if (internalOut[0]) seenOut <= 1'b1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   initial forever #4 clk = ~clk;
   initial begin
      {srcSel, gateSel, encBSel, armSel, auxSel, encASel, encZSel} = '0;
      {swArm, swDisarm, hwArmEn, loadStrobe, outToggle} = '0;
      {startMode, gateMode, dirMode, freqDiv, srcFalling, outInvert} = '0;
      {loadValue, progIoRoute, trigBusRoute, extLvl} = '0;
      {acqStart, freqEn, freqToDoClk, seenOut, freqToDiClk} = '0;
      freqSlowTb = 1'b1;
      n_fail = 0;
      samples_checked = 0;
      cycles = 0;
      clk = 1'b0;
      resetn = 1'b0;
      repeat (16) @(posedge clk);
      #1 resetn = 1'b1;
      t_reset;
      t_count;
      t_tc;
      t_latch;
      t_route;
      t_encoder;
      t_freq;
      tally_and_finish;
   end
endmodule // counter_signal_routing_tb

// file: verification/signal_source_model.sv
// Far-side sources: I/O lines, trigger bus lines, slow timebase
`timescale 1ns/10ps
module signal_source_model (
   input  wire logic   clk,
   output logic [15:0] progIoIn,
   output logic [7:0]  trigBusIn,
   output logic        timebase100k
);
   initial begin
      progIoIn = 16'h0000;
      trigBusIn = 8'h00;
      timebase100k = 1'b0;
   end
   // Free-running timebase, eight clocks a period
   initial forever begin
      repeat (4) @(posedge clk);
      #1 timebase100k = ~timebase100k;
   end
   // Lines 0-15 are I/O lines, 16-23 trigger bus lines
   task setLine(input integer n, input logic v);
      @(posedge clk);
      #1;
      if (n < 16) progIoIn[n] = v;
      else trigBusIn[n-16] = v;
   endtask
   // Each level held four clocks, above the sampling minimum
   task pulse(input integer n, input integer cnt);
      repeat (cnt) begin
         setLine(n, 1'b1);
         repeat (3) @(posedge clk);
         setLine(n, 1'b0);
         repeat (3) @(posedge clk);
      end
   endtask
endmodule // signal_source_model
